// [design/lsu_pkg.sv]
// shared constants and types for the load/store unit
package lsu_pkg;
  // operation codes presented on the issue port
  typedef enum logic [2:0] {
    LSU_OP_ISTORE,
    LSU_OP_IXFR,
    LSU_OP_FLOAD,
    LSU_OP_PFLOAD,
    LSU_OP_FSTORE
  } lsu_op_e;
  // operand size codes: byte, half, word, double, quad
  localparam logic [2:0] SZ_B = 3'h0;
  localparam logic [2:0] SZ_S = 3'h1;
  localparam logic [2:0] SZ_L = 3'h2;
  localparam logic [2:0] SZ_D = 3'h3;
  localparam logic [2:0] SZ_Q = 3'h4;
  localparam int IMM_W = 16;
  localparam int PIPE_DEPTH = 3;
  localparam logic [1:0] BUS_GAP = 2'h2;
  localparam logic [4:0] REG_ZERO = 5'h00;
endpackage

// [design/lsu_pipe_stage.sv]
// one stage of the pipelined load address queue
`timescale 1ns/100ps
`default_nettype none
module lsu_pipe_stage (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // shift control and data
  input wire logic shift,
  input wire logic [31:0] addr_in,
  input wire logic [2:0] size_in,
  input wire logic valid_in,
  output logic [31:0] addr_out,
  output logic [2:0] size_out,
  output logic valid_out
);
  logic [31:0] addr_q, addr_d;
  logic [2:0] size_q, size_d;
  logic valid_q, valid_d;

  // hold unless the queue advances
  always_comb begin
    addr_d = shift ? addr_in : addr_q;
    size_d = shift ? size_in : size_q;
    valid_d = shift ? valid_in : valid_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 32'h0;
      size_q <= 3'h0;
      valid_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      size_q <= size_d;
      valid_q <= valid_d;
    end
  end

  assign addr_out = addr_q;
  assign size_out = size_q;
  assign valid_out = valid_q;
endmodule
`default_nettype wire

// [design/lsu_top.sv]
// load/store execution unit: integer and float memory operations
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - integer store writes byte, half or word
// - store address is base plus signed offset
// - narrow stores keep only low bits
// - misaligned accesses raise data-access trap
// - register zero base contributes zero
// - offset low bits carry size, not address
// - integer to float copies bits unchanged
// - float loads 32/64/128 bits, index allowed
// - autoincrement writes effective address to base
// - float load hit returns cache, no bus
// - float load miss fetches and allocates
// - plain float loads leave queue untouched
// - three-stage pipelined load queue
// - pipelined miss fetches without allocating
// - pipelined hit uses cache only if modified
// - quad pipelined load traps on reduced variant
// - float loads never trap on bad numbers
// - bus takes one pipelined load per two cycles
// - float stores 32/64/128 bits at base plus offset or index
// - core interlocks until dependency met
module lsu_top #(
  parameter bit HAS_QUAD_PIPE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue port
  input wire logic issue_valid,
  input wire lsu_pkg::lsu_op_e issue_op,
  input wire logic [2:0] issue_size,
  input wire logic issue_autoinc,
  input wire logic issue_use_index,
  input wire logic [4:0] base_reg,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_operand,
  input wire logic [15:0] issue_imm,
  input wire logic [31:0] store_data_reg,
  input wire logic [127:0] fstore_data,
  output logic issue_ready,
  // register writeback
  output logic wb_int_valid,
  output logic [4:0] wb_int_reg,
  output logic [31:0] wb_int_data,
  output logic wb_fp_valid,
  output logic [2:0] wb_fp_size,
  output logic [127:0] wb_fp_data,
  // traps
  output logic trap_data,
  output logic trap_instr,
  // data cache
  output logic dc_req,
  output logic [31:0] dc_addr,
  output logic dc_pipe,
  input wire logic dc_hit,
  input wire logic dc_modified,
  input wire logic [127:0] dc_rdata,
  output logic dc_fill,
  output logic [127:0] dc_fill_data,
  // external bus
  output logic bus_req,
  output logic bus_we,
  output logic [31:0] bus_addr,
  output logic [2:0] bus_size,
  output logic [127:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [127:0] bus_rdata
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOOK, ST_BUS, ST_WB} lsu_state_e;

  lsu_state_e state_q, state_d;
  logic [31:0] ea;
  logic [31:0] off;
  logic [31:0] base_eff;
  logic misal;
  logic qtrap;
  logic accept;
  logic [1:0] gap_q, gap_d;
  logic [31:0] addr_q, addr_d;
  logic [2:0] size_q, size_d;
  logic pipe_q, pipe_d;
  logic [127:0] fwd_q, fwd_d;
  logic ready_q, ready_d;
  logic wbi_v_q, wbi_v_d;
  logic [4:0] wbi_r_q, wbi_r_d;
  logic [31:0] wbi_dat_q, wbi_dat_d;
  logic wbf_v_q, wbf_v_d;
  logic [2:0] wbf_s_q, wbf_s_d;
  logic [127:0] wbf_dat_q, wbf_dat_d;
  logic trd_q, trd_d, tri_q, tri_d;
  logic dcr_q, dcr_d, dcp_q, dcp_d, dcf_q, dcf_d;
  logic [127:0] dcfd_q, dcfd_d;
  logic breq_q, breq_d, bwe_q, bwe_d;
  logic [127:0] bwd_q, bwd_d;
  logic shift;
  logic [31:0] qa [0:3];
  logic [2:0] qs [0:3];
  logic qv [0:3];

  // zero base contributes nothing, offset low bits are size code only
  always_comb begin
    base_eff = (base_reg == lsu_pkg::REG_ZERO) ? 32'h0 : base_val;
    off = {{16{issue_imm[15]}}, issue_imm};
    // immediate bits below the size are the size code, never address
    case (issue_size)
      lsu_pkg::SZ_S: off[0] = 1'b0;
      lsu_pkg::SZ_L: off[1:0] = 2'h0;
      lsu_pkg::SZ_D: off[2:0] = 3'h0;
      lsu_pkg::SZ_Q: off[3:0] = 4'h0;
      default: off = off;
    endcase
    // an index is a full value; its low bits must reach the alignment check
    if (issue_use_index && issue_op != lsu_pkg::LSU_OP_ISTORE) begin
      off = index_operand;
    end
    ea = base_eff + off;
  end

  // alignment check against the operand size in bytes
  always_comb begin
    case (issue_size)
      lsu_pkg::SZ_B: misal = 1'b0;
      lsu_pkg::SZ_S: misal = ea[0];
      lsu_pkg::SZ_L: misal = |ea[1:0];
      lsu_pkg::SZ_D: misal = |ea[2:0];
      default: misal = |ea[3:0];
    endcase
    if (issue_op == lsu_pkg::LSU_OP_IXFR) begin
      misal = 1'b0;
    end
    qtrap = (issue_op == lsu_pkg::LSU_OP_PFLOAD) && (issue_size == lsu_pkg::SZ_Q)
      && !HAS_QUAD_PIPE;
  end

  // pipelined loads wait for the two-cycle bus slot
  assign accept = issue_valid && ready_q &&
    !(issue_op == lsu_pkg::LSU_OP_PFLOAD && gap_q != 2'h0);
  // queue advances only for accepted, trap-free pipelined loads
  assign shift = (state_q == ST_IDLE) && accept && issue_op == lsu_pkg::LSU_OP_PFLOAD
    && !misal && !qtrap;

  assign qa[0] = ea;
  assign qs[0] = issue_size;
  assign qv[0] = 1'b1;
  // three stages: oldest entry retires when a new one enters
  genvar gi;
  generate
    for (gi = 0; gi < lsu_pkg::PIPE_DEPTH; gi++) begin : g_q
      lsu_pipe_stage u_stage (
        .clk(clk),
        .rst_n(rst_n),
        .shift(shift),
        .addr_in(qa[gi]),
        .size_in(qs[gi]),
        .valid_in(qv[gi]),
        .addr_out(qa[gi+1]),
        .size_out(qs[gi+1]),
        .valid_out(qv[gi+1])
      );
    end
  endgenerate

  // control sequencing of accesses
  always_comb begin
    state_d = state_q;
    gap_d = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
    addr_d = addr_q;
    size_d = size_q;
    pipe_d = pipe_q;
    fwd_d = fwd_q;
    ready_d = ready_q;
    wbi_v_d = 1'b0;
    wbi_r_d = wbi_r_q;
    wbi_dat_d = wbi_dat_q;
    wbf_v_d = 1'b0;
    wbf_s_d = wbf_s_q;
    wbf_dat_d = wbf_dat_q;
    trd_d = 1'b0;
    tri_d = 1'b0;
    dcr_d = 1'b0;
    dcp_d = dcp_q;
    dcf_d = 1'b0;
    dcfd_d = dcfd_q;
    breq_d = breq_q;
    bwe_d = bwe_q;
    bwd_d = bwd_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          if (qtrap) begin
            tri_d = 1'b1;
          end else if (misal) begin
            trd_d = 1'b1;
          end else begin
            case (issue_op)
              lsu_pkg::LSU_OP_IXFR: begin
                wbf_v_d = 1'b1;
                wbf_s_d = lsu_pkg::SZ_L;
                wbf_dat_d = {96'h0, store_data_reg};
              end
              lsu_pkg::LSU_OP_ISTORE: begin
                ready_d = 1'b0;
                addr_d = ea;
                size_d = issue_size;
                breq_d = 1'b1;
                bwe_d = 1'b1;
                // narrow stores drop the upper source bits
                case (issue_size)
                  lsu_pkg::SZ_B: bwd_d = {120'h0, store_data_reg[7:0]};
                  lsu_pkg::SZ_S: bwd_d = {112'h0, store_data_reg[15:0]};
                  default: bwd_d = {96'h0, store_data_reg};
                endcase
                state_d = ST_BUS;
              end
              lsu_pkg::LSU_OP_FSTORE: begin
                ready_d = 1'b0;
                addr_d = ea;
                size_d = issue_size;
                breq_d = 1'b1;
                bwe_d = 1'b1;
                bwd_d = fstore_data;
                state_d = ST_BUS;
              end
              lsu_pkg::LSU_OP_FLOAD: begin
                ready_d = 1'b0;
                addr_d = ea;
                size_d = issue_size;
                pipe_d = 1'b0;
                dcr_d = 1'b1;
                dcp_d = 1'b0;
                state_d = ST_LOOK;
              end
              default: begin
                // pipelined load: look up the retiring address
                gap_d = lsu_pkg::BUS_GAP - 2'h1;
                if (qv[lsu_pkg::PIPE_DEPTH]) begin
                  ready_d = 1'b0;
                  addr_d = qa[lsu_pkg::PIPE_DEPTH];
                  size_d = qs[lsu_pkg::PIPE_DEPTH];
                  pipe_d = 1'b1;
                  dcr_d = 1'b1;
                  dcp_d = 1'b1;
                  state_d = ST_LOOK;
                end else begin
                  wbf_v_d = 1'b1;
                  wbf_s_d = issue_size;
                  wbf_dat_d = 128'h0;
                end
              end
            endcase
            // integer stores and register transfers have no autoincrement form
            if (issue_autoinc && issue_op != lsu_pkg::LSU_OP_ISTORE
              && issue_op != lsu_pkg::LSU_OP_IXFR) begin
              wbi_v_d = 1'b1;
              wbi_r_d = base_reg;
              wbi_dat_d = ea;
            end
          end
        end
      end
      ST_LOOK: begin
        // modified-line rule only applies to pipelined loads
        if (dc_hit && (!pipe_q || dc_modified)) begin
          fwd_d = dc_rdata;
          state_d = ST_WB;
        end else begin
          breq_d = 1'b1;
          bwe_d = 1'b0;
          state_d = ST_BUS;
        end
      end
      ST_BUS: begin
        if (bus_ack) begin
          breq_d = 1'b0;
          if (bwe_q) begin
            bwe_d = 1'b0;
            ready_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            fwd_d = bus_rdata;
            dcf_d = !pipe_q;
            dcfd_d = bus_rdata;
            state_d = ST_WB;
          end
        end
      end
      ST_WB: begin
        // raw pattern, no format check
        wbf_v_d = 1'b1;
        wbf_s_d = size_q;
        wbf_dat_d = fwd_q;
        ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      gap_q <= 2'h0;
      addr_q <= 32'h0;
      size_q <= 3'h0;
      pipe_q <= 1'b0;
      fwd_q <= 128'h0;
      ready_q <= 1'b1;
      wbi_v_q <= 1'b0;
      wbi_r_q <= 5'h0;
      wbi_dat_q <= 32'h0;
      wbf_v_q <= 1'b0;
      wbf_s_q <= 3'h0;
      wbf_dat_q <= 128'h0;
      trd_q <= 1'b0;
      tri_q <= 1'b0;
      dcr_q <= 1'b0;
      dcp_q <= 1'b0;
      dcf_q <= 1'b0;
      dcfd_q <= 128'h0;
      breq_q <= 1'b0;
      bwe_q <= 1'b0;
      bwd_q <= 128'h0;
    end else begin
      state_q <= state_d;
      gap_q <= gap_d;
      addr_q <= addr_d;
      size_q <= size_d;
      pipe_q <= pipe_d;
      fwd_q <= fwd_d;
      ready_q <= ready_d;
      wbi_v_q <= wbi_v_d;
      wbi_r_q <= wbi_r_d;
      wbi_dat_q <= wbi_dat_d;
      wbf_v_q <= wbf_v_d;
      wbf_s_q <= wbf_s_d;
      wbf_dat_q <= wbf_dat_d;
      trd_q <= trd_d;
      tri_q <= tri_d;
      dcr_q <= dcr_d;
      dcp_q <= dcp_d;
      dcf_q <= dcf_d;
      dcfd_q <= dcfd_d;
      breq_q <= breq_d;
      bwe_q <= bwe_d;
      bwd_q <= bwd_d;
    end
  end

  // outputs straight from flops
  assign issue_ready = ready_q;
  assign wb_int_valid = wbi_v_q;
  assign wb_int_reg = wbi_r_q;
  assign wb_int_data = wbi_dat_q;
  assign wb_fp_valid = wbf_v_q;
  assign wb_fp_size = wbf_s_q;
  assign wb_fp_data = wbf_dat_q;
  assign trap_data = trd_q;
  assign trap_instr = tri_q;
  assign dc_req = dcr_q;
  assign dc_addr = addr_q;
  assign dc_pipe = dcp_q;
  assign dc_fill = dcf_q;
  assign dc_fill_data = dcfd_q;
  assign bus_req = breq_q;
  assign bus_we = bwe_q;
  assign bus_addr = addr_q;
  assign bus_size = size_q;
  assign bus_wdata = bwd_q;

  // cache hit on a plain (non-pipelined) lookup never starts a bus cycle
  sequence s_hit_look;
    state_q == ST_LOOK && dc_hit && !pipe_q;
  endsequence
  a_hit_no_bus: assert property (@(posedge clk) disable iff (!rst_n)
    s_hit_look |=> !bus_req ##1 wb_fp_valid)
    else $error("cache hit issued bus cycle");
  a_mis_trap: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE && accept && misal && !qtrap) |=> trap_data && !bus_req)
    else $error("misaligned access not trapped");
  a_fill_plain: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_BUS && bus_ack && !bwe_q && !pipe_q) |=> dc_fill)
    else $error("plain load miss not allocated");
  a_no_fill_pipe: assert property (@(posedge clk) disable iff (!rst_n)
    dc_fill |-> !dc_pipe)
    else $error("pipelined load allocated");
  a_pipe_gap: assert property (@(posedge clk) disable iff (!rst_n)
    shift |=> !shift)
    else $error("pipelined loads too close");
  a_byte_mask: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_req && bus_we && bus_size == lsu_pkg::SZ_B) |-> bus_wdata[127:8] == 120'h0)
    else $error("byte store upper bits not dropped");
  a_quad_trap: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE && accept && qtrap) |=> trap_instr && !wb_fp_valid)
    else $error("quad pipelined load not trapped");
  a_ixfr_copy: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_IDLE && accept && issue_op == lsu_pkg::LSU_OP_IXFR)
    |=> wb_fp_valid && wb_fp_data[31:0] == $past(store_data_reg))
    else $error("transfer pattern altered");
  a_autoinc_wb: assert property (@(posedge clk) disable iff (!rst_n)
    (shift && issue_autoinc) |=> wb_int_valid && wb_int_data == $past(ea))
    else $error("autoincrement address not written");
endmodule
`default_nettype wire

// [tb/lsu_mem_model.sv]
// behavioural data cache and memory bus standing beside the load/store unit
`timescale 1ns/100ps
`default_nettype none
module lsu_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cache lookup
  input wire logic dc_req,
  input wire logic [31:0] dc_addr,
  output logic dc_hit,
  output logic dc_modified,
  output logic [127:0] dc_rdata,
  // memory bus
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0] ack_dly,
  output logic bus_ack,
  output logic [127:0] bus_rdata
);
  logic [3:0] wait_q;
  // memory image: each word holds the requested address xor its lane number
  function automatic logic [127:0] mval(input logic [31:0] a);
    return {a ^ 32'h3, a ^ 32'h2, a ^ 32'h1, a};
  endfunction
  // the unit samples the answer at the edge ending its request cycle, so answer at once
  // hit and dirty follow address bits 12 and 13; inverted junk when not answering
  assign dc_hit = dc_req ? dc_addr[12] : ~dc_addr[12];
  assign dc_modified = dc_req ? dc_addr[13] : ~dc_addr[13];
  // cached copy differs from memory so the source of a load is visible
  assign dc_rdata = dc_req ? ~mval(dc_addr) : mval(dc_addr);
  // bus acknowledge after ack_dly waiting cycles, one cycle wide
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (bus_req && !bus_ack && wait_q == ack_dly) begin
      bus_ack <= 1'b1;
      wait_q <= 4'h0;
    end else begin
      bus_ack <= 1'b0;
      wait_q <= (bus_req && !bus_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
  // read data is only good with the acknowledge
  assign bus_rdata = bus_ack ? mval(bus_addr) : ~mval(bus_addr);
endmodule
`default_nettype wire

// [tb/lsu_top_tb.sv]
// self-checking bench for the load/store unit
`timescale 1ns/100ps
`default_nettype none
module lsu_top_tb;
  typedef struct {
    lsu_pkg::lsu_op_e op;
    logic [2:0] sz;
    logic ai, ui;
    logic [4:0] br;
    logic [31:0] bv, ix;
    logic [15:0] im;
    logic [31:0] sd;
    logic et;
    int eb;
    logic [31:0] ea;
    logic [127:0] ed;
  } lsu_row_s;
  localparam logic [127:0] FS = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
  logic clk, rst_n, issue_valid, issue_autoinc, issue_use_index, issue_ready;
  lsu_pkg::lsu_op_e issue_op;
  logic [2:0] issue_size, wb_fp_size, bus_size;
  logic [4:0] base_reg, wb_int_reg;
  logic [31:0] base_val, index_operand, store_data_reg, wb_int_data, dc_addr, bus_addr, c_int, c_ba;
  logic [15:0] issue_imm;
  logic [127:0] fstore_data, wb_fp_data, dc_rdata, dc_fill_data, bus_wdata, bus_rdata, c_fp, c_wd;
  logic wb_int_valid, wb_fp_valid, trap_data, trap_instr, dc_req, dc_pipe, dc_hit;
  logic dc_modified, dc_fill, bus_req, bus_we, bus_ack, c_we;
  logic c_dp, rv_trap_instr;
  logic [2:0] c_fs, c_bs;
  logic [4:0] c_ir;
  logic [127:0] c_fd;
  logic [3:0] ack_dly;
  int bad_count, total_checks, cyc, n_fp, n_int, n_td, n_ti, n_bus, n_fill, n_look, n_rti;
  // op, size, autoinc, use index, base reg, base, index, imm, store data, trap, bus, addr, data
  lsu_row_s rows [20] = '{
    '{lsu_pkg::LSU_OP_ISTORE, lsu_pkg::SZ_B, '0, '0, 5'h3, 32'h1003, '0, 16'h0, 32'ha1b2c3d4, '0, 1, 32'h1003, 128'hd4},
    '{lsu_pkg::LSU_OP_ISTORE, lsu_pkg::SZ_S, '0, '0, 5'h3, 32'h1000, '0, 16'hfff3, 32'ha1b2c3d4, '0, 1, 32'hff2, 128'hc3d4},
    '{lsu_pkg::LSU_OP_ISTORE, lsu_pkg::SZ_L, '0, '0, 5'h0, 32'hdead0000, '0, 16'h7ffc, 32'ha1b2c3d4, '0, 1, 32'h7ffc, 128'ha1b2c3d4},
    '{lsu_pkg::LSU_OP_ISTORE, lsu_pkg::SZ_L, '0, '0, 5'h3, 32'h1002, '0, 16'h0, 32'h1, '1, 0, 32'h0, 128'h0},
    '{lsu_pkg::LSU_OP_IXFR, lsu_pkg::SZ_L, '0, '0, 5'h3, 32'h0, '0, 16'h0, 32'h7fc00001, '0, 0, 32'h0, 128'h7fc00001},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_L, '0, '1, 5'h4, 32'h1100, 32'h20, 16'h0, '0, '0, 0, 32'h0, 128'hffffeedf},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_D, '1, '1, 5'h4, 32'h200, 32'h8, 16'h0, '0, '0, 1, 32'h208, 128'h209_00000208},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_Q, '0, '1, 5'h4, 32'h300, 32'h10, 16'h0, '0, '0, 1, 32'h310,
      128'h313_00000312_00000311_00000310},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h700, '0, 16'h6, '0, '0, 1, 32'h704, 128'h704},
    '{lsu_pkg::LSU_OP_FSTORE, lsu_pkg::SZ_Q, '1, '1, 5'h4, 32'h400, 32'h30, 16'h0, '0, '0, 1, 32'h430, FS},
    '{lsu_pkg::LSU_OP_FSTORE, lsu_pkg::SZ_D, '0, '0, 5'h4, 32'h500, '0, 16'h13, '0, '0, 1, 32'h510, FS},
    '{lsu_pkg::LSU_OP_FSTORE, lsu_pkg::SZ_L, '1, '0, 5'h4, 32'h502, '0, 16'h0, '0, '1, 0, 32'h0, FS},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_D, '0, '1, 5'h4, 32'h604, '0, 16'h0, '0, '1, 0, 32'h0, 128'h0},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h800, '0, 16'h0, '0, '0, 0, 32'h0, 128'h0},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h3004, '0, 16'h0, '0, '0, 0, 32'h0, 128'h0},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '1, '0, 5'h4, 32'h1008, '0, 16'h0, '0, '0, 0, 32'h1008, 128'h0},
    '{lsu_pkg::LSU_OP_FLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h240, '0, 16'h0, '0, '0, 1, 32'h240, 128'h240},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h80c, '0, 16'h0, '0, '0, 1, 32'h800, 128'h800},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h810, '0, 16'h0, '0, '0, 0, 32'h0, 128'hffffcffb},
    '{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_L, '0, '0, 5'h4, 32'h814, '0, 16'h0, '0, '0, 1, 32'h1008, 128'h1008}
  };
  lsu_top lsu_top_i (.clk, .rst_n, .issue_valid, .issue_op, .issue_size, .issue_autoinc,
    .issue_use_index, .base_reg, .base_val, .index_operand, .issue_imm, .store_data_reg,
    .fstore_data, .issue_ready, .wb_int_valid, .wb_int_reg, .wb_int_data, .wb_fp_valid,
    .wb_fp_size, .wb_fp_data, .trap_data, .trap_instr, .dc_req, .dc_addr, .dc_pipe, .dc_hit,
    .dc_modified, .dc_rdata, .dc_fill, .dc_fill_data, .bus_req, .bus_we, .bus_addr, .bus_size,
    .bus_wdata, .bus_ack, .bus_rdata);
  lsu_mem_model lsu_mem_model_i (.clk, .rst_n, .dc_req, .dc_addr, .dc_hit, .dc_modified,
    .dc_rdata, .bus_req, .bus_addr, .ack_dly, .bus_ack, .bus_rdata);
  // reduced variant on the same stimulus; only its instruction trap is watched
  if (1) begin : g_reduced
    lsu_top #(.HAS_QUAD_PIPE(1'b0)) lsu_top_i (.clk, .rst_n, .issue_valid, .issue_op,
      .issue_size, .issue_autoinc, .issue_use_index, .base_reg, .base_val, .index_operand,
      .issue_imm, .store_data_reg, .fstore_data, .issue_ready(), .wb_int_valid(),
      .wb_int_reg(), .wb_int_data(), .wb_fp_valid(), .wb_fp_size(), .wb_fp_data(),
      .trap_data(), .trap_instr(rv_trap_instr), .dc_req(), .dc_addr(), .dc_pipe(), .dc_hit,
      .dc_modified, .dc_rdata, .dc_fill(), .dc_fill_data(), .bus_req(), .bus_we(),
      .bus_addr(), .bus_size(), .bus_wdata(), .bus_ack, .bus_rdata);
  end
  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // event capture; counters are cleared by the bench before each op
  always @(posedge clk) begin
    if (wb_fp_valid === 1'b1) begin n_fp++; c_fp = wb_fp_data; c_fs = wb_fp_size; end
    if (wb_int_valid === 1'b1) begin n_int++; c_int = wb_int_data; c_ir = wb_int_reg; end
    if (trap_data === 1'b1) n_td++;
    if (trap_instr === 1'b1) n_ti++;
    if (rv_trap_instr === 1'b1) n_rti++;
    if (dc_fill === 1'b1) begin n_fill++; c_fd = dc_fill_data; end
    if (dc_req === 1'b1) begin n_look++; c_dp = dc_pipe; end
    if (bus_req === 1'b1 && bus_ack === 1'b1) begin
      n_bus++; c_ba = bus_addr; c_wd = bus_wdata; c_we = bus_we; c_bs = bus_size;
    end
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("unexpected cycles: expected below 20000 seen %0d", cyc);
      end_of_test();
    end
  end
  task automatic chk_val(input string n, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin bad_count++; $display("unexpected %s: expected %h seen %h", n, e, g); end
  endtask
  task automatic chk_cnt(input string n, input int e, input int g);
    total_checks++;
    if (g != e) begin bad_count++; $display("unexpected %s: expected %0d seen %0d", n, e, g); end
  endtask
  // offer one op once the unit is ready; it is taken at the next rising edge
  task automatic put(input lsu_row_s r);
    int k;
    k = 0;
    while (issue_ready !== 1'b1 && k < 60) begin @(negedge clk); k++; end
    issue_valid = 1'b1; issue_op = r.op; issue_size = r.sz; issue_autoinc = r.ai;
    issue_use_index = r.ui; base_reg = r.br; base_val = r.bv; index_operand = r.ix;
    issue_imm = r.im; store_data_reg = r.sd;
    @(negedge clk);
    issue_valid = 1'b0;
  endtask
  task automatic run(input lsu_row_s r);
    logic [127:0] m;
    logic ld;
    logic lk;
    int k;
    m = {128{1'b1}} >> (128 - (8 << r.sz));
    ld = r.op inside {lsu_pkg::LSU_OP_IXFR, lsu_pkg::LSU_OP_FLOAD, lsu_pkg::LSU_OP_PFLOAD};
    // plain loads look up the cache, pipelined ones only when an address retires
    lk = !r.et && (r.op == lsu_pkg::LSU_OP_FLOAD
      || (r.op == lsu_pkg::LSU_OP_PFLOAD && (r.eb != 0 || r.ed != 0)));
    n_fp = 0; n_int = 0; n_td = 0; n_ti = 0; n_bus = 0; n_fill = 0; n_look = 0; n_rti = 0;
    put(r);
    k = 0;
    while ((issue_ready !== 1'b1 || bus_req !== 1'b0) && k < 60) begin @(negedge clk); k++; end
    repeat (3) @(negedge clk);
    chk_cnt("trap_data", r.et, n_td);
    chk_cnt("trap_instr", 0, n_ti);
    chk_cnt("bus_cycles", r.eb, n_bus);
    chk_cnt("fills", int'(r.op == lsu_pkg::LSU_OP_FLOAD && r.eb != 0), n_fill);
    chk_cnt("fp_writes", int'(ld && !r.et), n_fp);
    chk_cnt("base_writes", int'(r.ai && !r.et), n_int);
    if (r.eb != 0) chk_val("bus_addr", r.ea, c_ba);
    if (r.eb != 0) chk_val("bus_we", 128'(!ld), 128'(c_we));
    if (r.eb != 0 && !ld) chk_val("bus_wdata", r.ed & m, c_wd & m);
    if (ld && !r.et) chk_val("fp_data", r.ed & m, c_fp & m);
    if (r.ai && !r.et) chk_val("base_value", r.ea, c_int);
    if (r.ai && !r.et) chk_val("base_number", 128'(r.br), 128'(c_ir));
    if (ld && !r.et) chk_val("fp_size", 128'(r.sz), 128'(c_fs));
    if (r.eb != 0) chk_val("bus_size", 128'(r.sz), 128'(c_bs));
    if (r.op == lsu_pkg::LSU_OP_FLOAD && r.eb != 0)
      chk_val("fill_data", r.ed & m, c_fd & m);
    chk_cnt("lookups", int'(lk), n_look);
    if (lk) chk_val("dc_pipe", 128'(r.op == lsu_pkg::LSU_OP_PFLOAD), 128'(c_dp));
    $display("test %s at %h done", r.op.name(), r.bv);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0; issue_valid = 1'b0; issue_op = lsu_pkg::LSU_OP_ISTORE; issue_size = 3'h0;
    issue_autoinc = 1'b0; issue_use_index = 1'b0; base_reg = 5'h0; base_val = 32'h0;
    index_operand = 32'h0; issue_imm = 16'h0; store_data_reg = 32'h0; fstore_data = FS;
    ack_dly = 4'h0; bad_count = 0; total_checks = 0; cyc = 0;
    repeat (8) @(negedge clk);
    chk_val("ready_in_reset", 128'h1, 128'(issue_ready));
    chk_val("bus_req_in_reset", 128'h0, 128'(bus_req));
    rst_n = 1'b1;
    for (int i = 0; i < 20; i++) begin
      ack_dly = 4'(i % 3);
      run(rows[i]);
    end
    // reset while a store waits on a slow bus; the load queue must come back empty
    ack_dly = 4'hf;
    put(rows[2]);
    repeat (3) @(negedge clk);
    chk_val("bus_req_stalled", 128'h1, 128'(bus_req));
    rst_n = 1'b0;
    @(negedge clk);
    chk_val("ready_in_reset", 128'h1, 128'(issue_ready));
    chk_val("bus_req_in_reset", 128'h0, 128'(bus_req));
    rst_n = 1'b1;
    ack_dly = 4'h0;
    run(rows[13]);
    $display("test mid-run reset done");
    // quad pipelined load: the full part takes it, the reduced variant must trap
    run('{lsu_pkg::LSU_OP_PFLOAD, lsu_pkg::SZ_Q, '0, '0, 5'h4, 32'h900, '0, 16'h0, '0, '0, 0,
      32'h0, 128'h0});
    chk_cnt("trap_instr_reduced", 1, n_rti);
    end_of_test();
  end
endmodule
`default_nettype wire
